// ==== hdl/cwc_average.v ====
// auto-average update datapath for the capacitive wake-up compare
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_average #(
   parameter WIDTH = 8                        // measurement width
) (
   // sample and settings
   input  wire [WIDTH-1:0] sample,           // new measurement
   input  wire [WIDTH-1:0] old_avg,          // current average
   input  wire [1:0]       weight_code,      // weight select
   // result
   output wire [WIDTH-1:0] new_avg           // updated average
);
   // signed difference, one bit wider plus sign
   wire signed [WIDTH+1:0] diff;             // sample minus average
   wire signed [WIDTH+1:0] step;             // scaled difference
   wire [2:0]              shift;            // weight as shift
   wire [WIDTH+1:0]        sum;              // widened new average

   assign diff  = $signed({2'b00, sample}) - $signed({2'b00, old_avg});
   // code 00..11 selects weight 4..32
   assign shift = `CWC_WEIGHT_SHIFT0 + {1'b0, weight_code};
   // avg + (sample - avg) / weight
   assign step  = diff >>> shift;
   assign sum   = {2'b00, old_avg} + step;
   assign new_avg = sum[WIDTH-1:0];
endmodule // cwc_average

// ==== hdl/cwc_compare.v ====
// capacitive wake-up compare: registers, compare, average, interrupt
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_compare #(
   parameter WIDTH = 8                        // measurement width
) (
   // clock and reset
   input  wire             aclk,             // 50 MHz clock
   input  wire             aresetn,          // sync reset, low
   // measurement from converter front end
   input  wire [WIDTH-1:0] meas_data,        // measurement value
   input  wire             meas_valid,       // one-cycle done pulse
   // axi4-lite write address
   input  wire [31:0]      s_axi_awaddr,
   input  wire             s_axi_awvalid,
   output reg              s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]      s_axi_wdata,
   input  wire [3:0]       s_axi_wstrb,
   input  wire             s_axi_wvalid,
   output reg              s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]       s_axi_bresp,
   output reg              s_axi_bvalid,
   input  wire             s_axi_bready,
   // axi4-lite read address
   input  wire [31:0]      s_axi_araddr,
   input  wire             s_axi_arvalid,
   output reg              s_axi_arready,
   // axi4-lite read data
   output reg  [31:0]      s_axi_rdata,
   output reg  [1:0]       s_axi_rresp,
   output reg              s_axi_rvalid,
   input  wire             s_axi_rready,
   // interrupt
   output reg              irq               // level, high active
);
   // =========================================================
   // registers
   // =========================================================
   // register map, word index (byte address is four times the index):
   //   3B config     rw  delta 7:4, include 3, weight 2:1, ref sel 0
   //   3C reference  rw  fixed compare reference
   //   3D average    ro  running average, writes dropped
   //   3E result     ro  latest measurement
   //   3F identity   ro  chip type 7:3, revision 2:0
   //   40 status     ro  wake 0, measurement done 1, cleared by read
   //   41 mask       rw  interrupt enables, same layout as status
   //   anything else answers with a slave error
   //   the upper 24 read bits are always zero
   reg  [7:0]       config_reg;              // cap_wake_config
   reg  [7:0]       reference_reg;           // cap_wake_reference
   reg  [WIDTH-1:0] average_reg;             // cap_average_value
   reg  [WIDTH-1:0] result_reg;              // cap_latest_result
   reg  [1:0]       status_reg;              // sticky events
   reg  [1:0]       mask_reg;                // interrupt enables
   // write channel capture
   reg  [31:0]      waddr_reg;               // held write address
   reg              waddr_ok_reg;            // address captured
   reg  [31:0]      wdata_reg;               // held write data
   reg  [3:0]       wstrb_reg;               // held strobes
   reg              wdata_ok_reg;            // data captured

   // config fields, decoded straight from the register
   // every field is live: a write changes the next compare at once,
   // there is no shadow copy waiting for a measurement boundary
   wire [3:0] cap_delta_threshold =
              config_reg[`CWC_CFG_DELTA_HI:`CWC_CFG_DELTA_LO];
   wire       cap_avg_include_trigger = config_reg[`CWC_CFG_INCLUDE];
   wire [1:0] cap_avg_weight = config_reg[`CWC_CFG_WEIGHT_HI:
                                          `CWC_CFG_WEIGHT_LO];
   wire       cap_ref_from_average = config_reg[`CWC_CFG_REF_AVG];

   // =========================================================
   // compare datapath
   // =========================================================
   // a measurement is judged in the cycle its valid pulse stands:
   // reference select, magnitude and threshold test are all
   // combinational and land in flops at that one edge. with the
   // average as reference the compare sees the value from before
   // this sample, so a sample never judges itself.
   // the front end must not pulse valid on two adjacent cycles with
   // different data expecting both to be judged against one average.
   wire [WIDTH-1:0] ref_sel;                 // selected reference
   wire [WIDTH-1:0] cap_delta;               // absolute difference
   wire             trigger;                 // exceeds threshold
   wire             avg_update;              // average takes sample
   wire [WIDTH-1:0] avg_new;                 // updated average

   // register or running average as reference
   assign ref_sel = cap_ref_from_average ? average_reg
                                         : reference_reg[WIDTH-1:0];
   // magnitude of the difference, either sign; the larger minus the
   // smaller never wraps, so no extra sign bit is needed
   assign cap_delta = (meas_data >= ref_sel) ?
                      meas_data - ref_sel : ref_sel - meas_data;
   // strictly greater than the delta threshold; a threshold of zero
   // fires on any change at all
   assign trigger = meas_valid &&
                    (cap_delta > {{(WIDTH-4){1'b0}}, cap_delta_threshold});
   // triggering sample joins average only when included; excluding it
   // keeps a sudden touch from dragging the reference towards itself
   assign avg_update = meas_valid &&
                       (!trigger || cap_avg_include_trigger);

   // average step: old + (sample - old) / weight, floor division by
   // an arithmetic shift; the result never leaves the sample range
   // because the step is at most the distance to the sample
   cwc_average #(
      .WIDTH       (WIDTH)
   ) u_average (
      .sample      (meas_data),
      .old_avg     (average_reg),
      .weight_code (cap_avg_weight),
      .new_avg     (avg_new)
   );

   // latest result and average update
   always @(posedge aclk) begin
      // both display values read zero after reset
      if (!aresetn) begin
         result_reg  <= {WIDTH{1'b0}};
         average_reg <= {WIDTH{1'b0}};
      end else begin
         if (meas_valid) begin
            result_reg <= meas_data;
         end
         if (avg_update) begin
            average_reg <= avg_new;
         end
      end
   end

   // =========================================================
   // axi4-lite write side
   // =========================================================
   // address and data are captured separately and may come in either
   // order; the register is written and the response raised at the
   // edge after both are held. while a response waits, both readies
   // stay low, so a second write cannot slip in before the master
   // has taken the answer.
   wire       aw_take = s_axi_awvalid && s_axi_awready;
   wire       w_take  = s_axi_wvalid && s_axi_wready;
   wire       do_write = waddr_ok_reg && wdata_ok_reg && !s_axi_bvalid;
   wire [7:0] widx = waddr_reg[9:2];         // word index
   wire       wmapped = (waddr_reg[31:10] == 22'h0) &&
                        (widx >= `CWC_IDX_CONFIG) &&
                        (widx <= `CWC_IDX_IRQ_MASK);

   // capture address and data in either order, answer after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         // nothing offered and nothing held in reset
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CWC_RESP_OKAY;
         waddr_ok_reg  <= 1'b0;
         wdata_ok_reg  <= 1'b0;
         waddr_reg     <= 32'h0000_0000;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
      end else begin
         // ready for a channel while nothing held there
         s_axi_awready <= !waddr_ok_reg && !aw_take && !s_axi_bvalid;
         s_axi_wready  <= !wdata_ok_reg && !w_take && !s_axi_bvalid;
         if (aw_take) begin
            waddr_reg    <= s_axi_awaddr;
            waddr_ok_reg <= 1'b1;
         end
         if (w_take) begin
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            wdata_ok_reg <= 1'b1;
         end
         // both halves held: answer and free the holding flags
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wmapped ? `CWC_RESP_OKAY : `CWC_RESP_SLVERR;
            waddr_ok_reg <= 1'b0;
            wdata_ok_reg <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            // master took the response
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register writes, low byte lane only
   // a write that lacks the low strobe still gets an okay answer
   always @(posedge aclk) begin
      if (!aresetn) begin
         config_reg    <= `CWC_RST_BYTE;
         reference_reg <= `CWC_RST_BYTE;
         mask_reg      <= 2'h0;
      end else if (do_write && wstrb_reg[0]) begin
         case (widx)
            `CWC_IDX_CONFIG: config_reg <= wdata_reg[7:0];
            `CWC_IDX_REFERENCE: reference_reg <= wdata_reg[7:0];
            `CWC_IDX_IRQ_MASK:  mask_reg      <= wdata_reg[1:0];
            // average, result, identity: writes ignored
            default: ;
         endcase
      end
   end

   // =========================================================
   // axi4-lite read side
   // =========================================================
   // the read mux is decoded from the address while it is offered and
   // latched at the take, so rdata stands unchanged until rready.
   // reading the status word clears it at that same edge; the value
   // returned is the one from before the clear.
   wire       ar_take = s_axi_arvalid && s_axi_arready;
   wire [7:0] ridx = s_axi_araddr[9:2];      // word index
   wire       rhigh = (s_axi_araddr[31:10] != 22'h0);
   reg  [7:0] rbyte;                         // selected register
   reg        rmapped;                       // address decoded
   wire       status_read = ar_take && !rhigh &&
                            (ridx == `CWC_IDX_IRQ_STATUS);

   // read mux
   always @* begin
      rbyte   = 8'h00;
      rmapped = !rhigh;
      case (ridx)
         `CWC_IDX_CONFIG:     rbyte = config_reg;
         `CWC_IDX_REFERENCE:  rbyte = reference_reg;
         `CWC_IDX_AVERAGE:    rbyte = average_reg;
         `CWC_IDX_RESULT:     rbyte = result_reg;
         `CWC_IDX_IDENTITY:
            rbyte = {`CWC_CHIP_TYPE, `CWC_CHIP_REV};
         `CWC_IDX_IRQ_STATUS: rbyte = {6'h00, status_reg};
         `CWC_IDX_IRQ_MASK:   rbyte = {6'h00, mask_reg};
         default:             rmapped = 1'b0;
      endcase
   end

   // one read at a time; answer the cycle after acceptance
   always @(posedge aclk) begin
      if (!aresetn) begin
         // idle read channel in reset
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CWC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            // latch data and response for the whole wait
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rbyte};
            s_axi_rresp  <= rmapped ? `CWC_RESP_OKAY : `CWC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            // master took the data
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =========================================================
   // interrupt status
   // =========================================================
   // two event sources: a wake compare hit and every finished
   // measurement. status bits stay set until software reads the
   // status word; the level output takes the masked next status at
   // the same edge as status itself, from flops only.
   // clearing a mask bit drops the output without losing status.
   reg [1:0] events;                         // this-cycle events

   // a new event wins over the read-clear
   always @* begin
      events = 2'h0;
      events[`CWC_IRQ_WAKE] = trigger;
      events[`CWC_IRQ_MEAS] = meas_valid;
   end

   // sticky status, cleared by reading it; irq from masked status
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= 2'h0;
         irq        <= 1'b0;
      end else begin
         if (status_read) begin
            // read clears, but an event in the same cycle survives
            status_reg <= events;
         end else begin
            // collect new events on top of what is pending
            status_reg <= status_reg | events;
         end
         // same next-state selection as above, masked
         irq <= |(mask_reg & (status_read ? events : (status_reg | events)));
      end
   end
endmodule // cwc_compare

// ==== hdl/cwc_defs.vh ====
// constants for the capacitive wake-up compare block
`ifndef CWC_DEFS_VH
`define CWC_DEFS_VH
// register indices (byte address is four times the index)
`define CWC_IDX_CONFIG      8'h3B
`define CWC_IDX_REFERENCE   8'h3C
`define CWC_IDX_AVERAGE     8'h3D
`define CWC_IDX_RESULT      8'h3E
`define CWC_IDX_IDENTITY    8'h3F
`define CWC_IDX_IRQ_STATUS  8'h40
`define CWC_IDX_IRQ_MASK    8'h41
// config field positions
`define CWC_CFG_DELTA_HI    7
`define CWC_CFG_DELTA_LO    4
`define CWC_CFG_INCLUDE     3
`define CWC_CFG_WEIGHT_HI   2
`define CWC_CFG_WEIGHT_LO   1
`define CWC_CFG_REF_AVG     0
// reset values
`define CWC_RST_BYTE        8'h00
// weight code to shift: 4,8,16,32 -> 2,3,4,5
`define CWC_WEIGHT_SHIFT0   3'h2
// identity fields (arbitrary neutral values)
`define CWC_CHIP_TYPE       5'h11
`define CWC_CHIP_REV        3'h1
// irq status bits
`define CWC_IRQ_WAKE        0
`define CWC_IRQ_MEAS        1
// axi responses
`define CWC_RESP_OKAY       2'h0
`define CWC_RESP_SLVERR     2'h2
`endif

// ==== sim/cwc_checker.sv ====
// port assertions for the capacitive wake-up compare block
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_checker (
   // clock, reset and watched bus ports
   input wire        aclk, aresetn,
   input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire        s_axi_wready, s_axi_bvalid, s_axi_bready,
   input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [1:0]  s_axi_bresp, s_axi_rresp,
   input wire [31:0] s_axi_araddr, s_axi_rdata
);
   // ==========================================
   // bus timing
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write halves taken at one edge
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // read address taken
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after take");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read data not one cycle after take");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   a_aw_refused: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_ident_const: assert property (s_rd_take and
      (s_axi_araddr == 32'h000000FC)
      |=> s_axi_rdata == {24'h000000, `CWC_CHIP_TYPE, `CWC_CHIP_REV})
      else $error("identity byte wrong");
   a_unmapped_err: assert property (s_rd_take and
      (s_axi_araddr == 32'h00000200)
      |=> s_axi_rresp == `CWC_RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule // cwc_checker
bind cwc_compare cwc_checker cwc_checker_inst (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rresp,
   .s_axi_araddr, .s_axi_rdata);

// ==== sim/cwc_compare_tb_top.sv ====
// self-checking bench for the capacitive wake-up compare block
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_compare_tb_top;
   // ==========================================
   // stimulus, shadows and design outputs
   logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic [7:0]  value = 8'h00, cfg = 8'h00, refv = 8'h00, msk = 8'h00;
   logic [7:0]  meas_data;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, irq, meas_valid;
   int          errors, checks_done, avg;
   cwc_compare #(.WIDTH(8)) cwc_compare_inst (.aclk, .aresetn, .meas_data,
      .meas_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq);
   cwc_meas_model cwc_meas_model_inst (.aclk, .go, .value, .meas_data,
      .meas_valid);
   always #10 aclk = ~aclk;
   // compare and count
   task automatic chk(input [31:0] got, input [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // bus write; shadows follow what software wrote
   task automatic wr(input [7:0] idx, input [7:0] d);
      int n = 0;
      @(posedge aclk);
      s_axi_awaddr <= {22'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      chk(s_axi_bvalid, 1, "write answered");
      chk(s_axi_bresp, (idx >= `CWC_IDX_CONFIG && idx <= `CWC_IDX_IRQ_MASK)
          ? `CWC_RESP_OKAY : `CWC_RESP_SLVERR, "write response");
      if (idx == `CWC_IDX_CONFIG) cfg = d;
      if (idx == `CWC_IDX_REFERENCE) refv = d;
      if (idx == `CWC_IDX_IRQ_MASK) msk = d;
   endtask
   // bus read, data and response taken at the answer edge
   task automatic rd(input [7:0] idx, output [31:0] d, output [1:0] r);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr <= {22'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      chk(s_axi_rvalid, 1, "read answered");
      s_axi_rready <= 1'b0;
   endtask
   // one measurement, judged against a reference model of the block
   task automatic meas(input [7:0] v);
      logic [31:0] d;
      logic [1:0]  r;
      int          df = int'(v) - (cfg[0] ? avg : int'(refv));
      bit          trig = df > int'(cfg[7:4]) || -df > int'(cfg[7:4]);
      if (!trig || cfg[3]) avg = avg + ((int'(v) - avg) >>> (cfg[2:1] + 2));
      @(posedge aclk);
      go <= 1'b1;
      value <= v;
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(irq, (trig & msk[0]) | msk[1], "irq level");
      rd(`CWC_IDX_IRQ_STATUS, d, r);
      chk(d[0], trig, "wake flag");
      chk(d[1], 1, "done flag");
      rd(`CWC_IDX_RESULT, d, r);
      chk(d, v, "latest result");
      rd(`CWC_IDX_AVERAGE, d, r);
      chk(d, avg, "average value");
   endtask
   // reset values, access kinds, unmapped address
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 4; i++) begin
         rd(8'(`CWC_IDX_CONFIG + i), d, r);
         chk(d, 0, "reset value");
      end
      wr(`CWC_IDX_IDENTITY, 8'h00);
      rd(`CWC_IDX_IDENTITY, d, r);
      chk(d, {`CWC_CHIP_TYPE, `CWC_CHIP_REV}, "identity");
      wr(`CWC_IDX_CONFIG, 8'hA5);
      rd(`CWC_IDX_CONFIG, d, r);
      chk(d, 8'hA5, "config readback");
      wr(`CWC_IDX_REFERENCE, 8'h5A);
      rd(`CWC_IDX_REFERENCE, d, r);
      chk(d, 8'h5A, "reference readback");
      wr(`CWC_IDX_AVERAGE, 8'h77);
      rd(`CWC_IDX_AVERAGE, d, r);
      chk(d, 0, "average write ignored");
      wr(8'h80, 8'h11);
      rd(8'h80, d, r);
      chk(d, 0, "unmapped data");
      chk(r, `CWC_RESP_SLVERR, "unmapped read");
   endtask
   // register reference: threshold edges, both directions, masking
   task automatic t_ref();
      wr(`CWC_IDX_IRQ_MASK, 8'h01);
      wr(`CWC_IDX_REFERENCE, 8'h64);
      for (int k = 3; k < 16; k += 12) begin
         wr(`CWC_IDX_CONFIG, 8'(k << 4));
         meas(8'(100 + k));
         meas(8'(101 + k));
         meas(8'(99 - k));
      end
      wr(`CWC_IDX_IRQ_MASK, 8'h00);
      meas(8'hC8);
      wr(`CWC_IDX_IRQ_MASK, 8'h01);
      meas(8'h10);
      chk(irq, 0, "irq after status read");
   endtask
   // average reference: every weight, include and exclude
   task automatic t_avg();
      for (int w = 0; w < 4; w++) begin
         wr(`CWC_IDX_CONFIG, 8'(w * 2 + 9));
         meas(8'hF0);
         meas(8'h20);
      end
      wr(`CWC_IDX_CONFIG, 8'h51);
      meas(8'(avg + 40));
      meas(8'(avg + 5));
   endtask
   // verdict and end of run
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // main sequence after an eight-cycle reset
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_ref();
      t_avg();
      give_verdict();
   end
   // watchdog against a hung handshake
   initial begin
      #400000;
      errors++;
      give_verdict();
   end
endmodule // cwc_compare_tb_top

// ==== sim/cwc_meas_model.sv ====
// behavioural converter front end feeding measurement results
`timescale 1ns/1ps
module cwc_meas_model (
   // clock and request from the bench
   input  wire       aclk,
   input  wire       go,
   input  wire [7:0] value,
   // result towards the block
   output reg  [7:0] meas_data = 8'h00,
   output reg        meas_valid = 1'b0
);
   // one-cycle done pulse; data toggles when stale so nothing lingers
   always @(posedge aclk) begin
      meas_valid <= go;
      meas_data  <= go ? value : ~meas_data;
   end
endmodule // cwc_meas_model
